//--- vsfs_params.svh
// Register offsets, field positions, reset values and timing figures of the setpoint block.
`ifndef VSFS_PARAMS_SVH
`define VSFS_PARAMS_SVH
`define VSFS_OFF_CTRL 8'h00
`define VSFS_OFF_NOMINAL 8'h04
`define VSFS_OFF_UPPER 8'h08
`define VSFS_OFF_LOWER 8'h0C
`define VSFS_OFF_USER 8'h10
`define VSFS_OFF_FACTORY 8'h14
`define VSFS_OFF_LOADLINE 8'h18
`define VSFS_OFF_CEILING 8'h1C
`define VSFS_OFF_LOOP_GAIN 8'h20
`define VSFS_OFF_MON_GAIN 8'h24
`define VSFS_OFF_FORMAT 8'h28
`define VSFS_OFF_REFERENCE 8'h2C
`define VSFS_OFF_READBACK 8'h30
`define VSFS_OFF_STATUS 8'h34
`define VSFS_OFF_DETAIL0 8'h40
`define VSFS_CTRL_CLEAR_BIT 8
`define VSFS_CTRL_RST 5'h04
`define VSFS_NOMINAL_RST 16'h0000
`define VSFS_CEILING_RST 16'hFFFF
`define VSFS_GAIN_RST 16'h8000
`define VSFS_FORMAT_RST 8'h00
`define VSFS_ALARM_BIT 3
`define VSFS_CLK_NS 5
`define VSFS_DELAY_NS 10000
`define VSFS_RETRY_NS 200000
`define VSFS_DELAY_CYC (`VSFS_DELAY_NS / `VSFS_CLK_NS)
`define VSFS_RETRY_CYC (`VSFS_RETRY_NS / `VSFS_CLK_NS)
`endif

//--- vsfs_pkg.sv
// Types shared by the setpoint and status block.
package vsfs_pkg;
    typedef enum logic [1:0] {
        MODE_NOMINAL = 2'h0,
        MODE_UPPER = 2'h1,
        MODE_LOWER = 2'h2,
        MODE_RSVD = 2'h3
    } op_mode_t;
    typedef enum logic [1:0] {
        RESP_CONTINUE = 2'h0,
        RESP_LATCH_OFF = 2'h1,
        RESP_RETRY = 2'h2,
        RESP_DELAY = 2'h3
    } fault_resp_t;
    typedef struct packed {
        fault_resp_t resp;
        logic out_on;
        op_mode_t mode;
    } ctrl_t;
    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_DELAY = 4'h2,
        ST_RETRY = 4'h4,
        ST_OFF = 4'h8
    } pwr_state_t;
endpackage : vsfs_pkg

//--- vout_setpoint_fault_status.sv
// Output voltage setpoint datapath and latched fault/warning status with an APB register port.
//
// Summary of operation
// - Base setpoint picked from nominal, upper or lower margin by operating mode.
// - Signed user offset is added to the chosen base setpoint.
// - Signed factory offset is then added to the running command.
// - Positive current times load-line coefficient is subtracted; never raises command.
// - Command above ceiling is replaced by ceiling and raises the ceiling alarm.
// - Limited command is multiplied by the loop divider gain.
// - Scaled result is the reference output for the control loop.
// - Limited command entering the gain is sixteen bits wide.
// - Sensed output passes its own monitor divider gain for readback.
// - One read register per monitored value.
// - An exceeded threshold latches its own dedicated status bit.
// - Warnings set their bit, keep running and wait for polling.
// - Faults set their bit and run the programmed shutdown response.
// - Bits persist until clear command, reset pin, output off-on, or power loss.
// - A condition still present at clear sets its bit again at once.
// - Status in three levels: summary byte, summary word, detail registers.
// - Summary word low byte is the summary byte, extra bits above.
// - Seven detail status registers, chosen by summary bits.
// - Each status bit is set without disturbing others.
// - A clear resets all bits of all status registers together.
// - Format write is refused when the format is fixed.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "vsfs_params.svh"

module vout_setpoint_fault_status #(
    parameter int DETAIL_N = 7,
    parameter int GAIN_FRAC = 16,
    parameter int LL_FRAC = 8,
    parameter int DELAY_CYC = `VSFS_DELAY_CYC,
    parameter int RETRY_CYC = `VSFS_RETRY_CYC,
    parameter bit FORMAT_WRITABLE = 1'b0
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter side.
    input wire logic signed [15:0] iout_in,
    input wire logic [15:0] sense_in,
    input wire logic [8*DETAIL_N-1:0] cond_in,
    input wire logic ctrl_pin,
    input wire logic reset_pin,
    output logic [15:0] vref,
    output logic out_enable,
    output logic ceiling_alarm
);

    // ----------------------------------------------------------------
    // Registers.
    // ----------------------------------------------------------------
    vsfs_pkg::ctrl_t ctrl_r;
    logic [15:0] nominal_setpoint_r, upper_margin_setpoint_r, lower_margin_setpoint_r;
    logic signed [15:0] user_offset_r, factory_offset_r;
    logic [15:0] load_line_coeff_r, setpoint_ceiling_r;
    logic [15:0] loop_divider_gain_r, monitor_divider_gain_r;
    logic [7:0] voltage_format_select_r;
    logic [15:0] setpt_r, output_level_readback_r;
    logic [7:0] detail_r [DETAIL_N];
    logic clr_cmd_r, en_q_r;
    vsfs_pkg::pwr_state_t state_r;
    logic [31:0] cnt_r;

    logic wr_go, setup;
    assign setup = psel & ~penable;
    assign wr_go = psel & penable & pwrite & pready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= vsfs_pkg::ctrl_t'(`VSFS_CTRL_RST);
            nominal_setpoint_r <= `VSFS_NOMINAL_RST;
            upper_margin_setpoint_r <= `VSFS_NOMINAL_RST;
            lower_margin_setpoint_r <= `VSFS_NOMINAL_RST;
            user_offset_r <= 16'sh0000;
            factory_offset_r <= 16'sh0000;
            load_line_coeff_r <= 16'h0000;
            setpoint_ceiling_r <= `VSFS_CEILING_RST;
            loop_divider_gain_r <= `VSFS_GAIN_RST;
            monitor_divider_gain_r <= `VSFS_GAIN_RST;
            voltage_format_select_r <= `VSFS_FORMAT_RST;
        end else if (wr_go) begin
            unique case (paddr)
                `VSFS_OFF_CTRL: ctrl_r <= vsfs_pkg::ctrl_t'(pwdata[4:0]);
                `VSFS_OFF_NOMINAL: nominal_setpoint_r <= pwdata[15:0];
                `VSFS_OFF_UPPER: upper_margin_setpoint_r <= pwdata[15:0];
                `VSFS_OFF_LOWER: lower_margin_setpoint_r <= pwdata[15:0];
                `VSFS_OFF_USER: user_offset_r <= pwdata[15:0];
                `VSFS_OFF_FACTORY: factory_offset_r <= pwdata[15:0];
                `VSFS_OFF_LOADLINE: load_line_coeff_r <= pwdata[15:0];
                `VSFS_OFF_CEILING: setpoint_ceiling_r <= pwdata[15:0];
                `VSFS_OFF_LOOP_GAIN: loop_divider_gain_r <= pwdata[15:0];
                `VSFS_OFF_MON_GAIN: monitor_divider_gain_r <= pwdata[15:0];
                `VSFS_OFF_FORMAT: begin
                    if (FORMAT_WRITABLE) begin
                        voltage_format_select_r <= pwdata[7:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Setpoint datapath.
    // ----------------------------------------------------------------
    logic [15:0] base;
    logic signed [18:0] trimmed;
    logic [15:0] iout_pos;
    logic [31:0] droop;
    logic signed [34:0] drooped;
    logic [15:0] limited, no_droop;
    logic ceil_hit;
    logic [31:0] loop_prod, mon_prod;

    always_comb begin
        unique case (ctrl_r.mode)
            vsfs_pkg::MODE_UPPER: base = upper_margin_setpoint_r;
            vsfs_pkg::MODE_LOWER: base = lower_margin_setpoint_r;
            default: base = nominal_setpoint_r;
        endcase
    end

    // Nineteen bits hold the base plus two full-range offsets without wrapping.
    assign trimmed = $signed({3'h0, base}) + 19'(user_offset_r)
        + 19'(factory_offset_r);
    // Negative current contributes nothing, so droop can only pull the command down.
    assign iout_pos = iout_in[15] ? 16'h0000 : iout_in;
    assign droop = 32'(load_line_coeff_r) * 32'(iout_pos);
    assign drooped = 35'(trimmed) - $signed({3'h0, droop >> LL_FRAC});

    always_comb begin
        ceil_hit = 1'b0;
        if (drooped < 0) begin
            limited = 16'h0000;
        end else if (drooped > $signed({19'h0, setpoint_ceiling_r})) begin
            limited = setpoint_ceiling_r;
            ceil_hit = 1'b1;
        end else begin
            limited = drooped[15:0];
        end
        if (trimmed < 0) begin
            no_droop = 16'h0000;
        end else if (trimmed > $signed({3'h0, setpoint_ceiling_r})) begin
            no_droop = setpoint_ceiling_r;
        end else begin
            no_droop = trimmed[15:0];
        end
    end

    assign loop_prod = 32'(setpt_r) * 32'(loop_divider_gain_r);
    assign mon_prod = 32'(sense_in) * 32'(monitor_divider_gain_r);

    // Two register stages keep the multiplier off the clamp path.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setpt_r <= 16'h0000;
            vref <= 16'h0000;
            ceiling_alarm <= 1'b0;
            output_level_readback_r <= 16'h0000;
        end else begin
            setpt_r <= limited;
            ceiling_alarm <= ceil_hit;
            vref <= 16'(loop_prod >> GAIN_FRAC);
            output_level_readback_r <= 16'(mon_prod >> GAIN_FRAC);
        end
    end

    // ----------------------------------------------------------------
    // Status registers.
    // ----------------------------------------------------------------
    logic en_cmd, clr_req;
    logic [7:0] det_cond [DETAIL_N];
    logic [DETAIL_N-1:0] sum_bits, fault_bits, warn_bits;
    logic [15:0] status_word;

    assign en_cmd = ctrl_r.out_on & ctrl_pin;
    // Clear command, reset pin, or output switched off and back on.
    assign clr_req = clr_cmd_r | reset_pin | (en_cmd & ~en_q_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clr_cmd_r <= 1'b0;
            en_q_r <= 1'b0;
        end else begin
            clr_cmd_r <= wr_go & (paddr == `VSFS_OFF_CTRL)
                & pwdata[`VSFS_CTRL_CLEAR_BIT];
            en_q_r <= en_cmd;
        end
    end

    // Upper nibble of each detail register is faults, lower nibble warnings.
    for (genvar k = 0; k < DETAIL_N; k++) begin : g_detail
        assign det_cond[k] = cond_in[8*k +: 8]
            | ((k == 0) ? (8'(ceiling_alarm) << `VSFS_ALARM_BIT) : 8'h00);
        assign sum_bits[k] = |detail_r[k];
        assign fault_bits[k] = |det_cond[k][7:4];
        assign warn_bits[k] = |detail_r[k][3:0];
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                detail_r[k] <= 8'h00;
            end else begin
                // Set wins over clear so a live condition is never lost.
                detail_r[k] <= (clr_req ? 8'h00 : detail_r[k])
                    | det_cond[k];
            end
        end
    end

    assign status_word = {5'h00, |warn_bits, |fault_bits, ~out_enable,
        state_r == vsfs_pkg::ST_OFF, sum_bits};

    // ----------------------------------------------------------------
    // Fault response.
    // ----------------------------------------------------------------
    logic fault_now;
    assign fault_now = |fault_bits;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= vsfs_pkg::ST_RUN;
            cnt_r <= 32'h0;
        end else begin
            cnt_r <= cnt_r + 32'h1;
            unique case (state_r)
                vsfs_pkg::ST_RUN: begin
                    cnt_r <= 32'h0;
                    if (fault_now & en_cmd) begin
                        unique case (ctrl_r.resp)
                            vsfs_pkg::RESP_LATCH_OFF: state_r <= vsfs_pkg::ST_OFF;
                            vsfs_pkg::RESP_RETRY: state_r <= vsfs_pkg::ST_RETRY;
                            vsfs_pkg::RESP_DELAY: state_r <= vsfs_pkg::ST_DELAY;
                            default: ;
                        endcase
                    end
                end
                vsfs_pkg::ST_DELAY: begin
                    if (!fault_now) begin
                        state_r <= vsfs_pkg::ST_RUN;
                    end else if (cnt_r == 32'(DELAY_CYC - 1)) begin
                        state_r <= vsfs_pkg::ST_OFF;
                    end
                end
                vsfs_pkg::ST_RETRY: begin
                    if (cnt_r == 32'(RETRY_CYC - 1)) begin
                        state_r <= vsfs_pkg::ST_RUN;
                    end
                end
                vsfs_pkg::ST_OFF: begin
                    if (clr_req) begin
                        state_r <= vsfs_pkg::ST_RUN;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_enable <= 1'b0;
        end else begin
            out_enable <= en_cmd & (state_r inside {vsfs_pkg::ST_RUN, vsfs_pkg::ST_DELAY});
        end
    end

    // ----------------------------------------------------------------
    // APB read and answer.
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;
    logic rd_err;
    logic [7:0] det_idx;
    assign det_idx = (paddr - `VSFS_OFF_DETAIL0) >> 2;

    always_comb begin
        rd_err = 1'b0;
        rd_mux = 32'h0;
        unique case (paddr)
            `VSFS_OFF_CTRL: rd_mux = {27'h0, ctrl_r};
            `VSFS_OFF_NOMINAL: rd_mux = {16'h0, nominal_setpoint_r};
            `VSFS_OFF_UPPER: rd_mux = {16'h0, upper_margin_setpoint_r};
            `VSFS_OFF_LOWER: rd_mux = {16'h0, lower_margin_setpoint_r};
            `VSFS_OFF_USER: rd_mux = {16'h0, user_offset_r};
            `VSFS_OFF_FACTORY: rd_mux = {16'h0, factory_offset_r};
            `VSFS_OFF_LOADLINE: rd_mux = {16'h0, load_line_coeff_r};
            `VSFS_OFF_CEILING: rd_mux = {16'h0, setpoint_ceiling_r};
            `VSFS_OFF_LOOP_GAIN: rd_mux = {16'h0, loop_divider_gain_r};
            `VSFS_OFF_MON_GAIN: rd_mux = {16'h0, monitor_divider_gain_r};
            `VSFS_OFF_FORMAT: begin
                rd_mux = {24'h0, voltage_format_select_r};
                rd_err = pwrite & ~FORMAT_WRITABLE;
            end
            `VSFS_OFF_REFERENCE: rd_mux = {16'h0, vref};
            `VSFS_OFF_READBACK: rd_mux = {16'h0, output_level_readback_r};
            `VSFS_OFF_STATUS: rd_mux = {16'h0, status_word};
            default: begin
                if (paddr >= `VSFS_OFF_DETAIL0 && paddr[1:0] == 2'h0
                        && det_idx < 8'(DETAIL_N)) begin
                    rd_mux = {24'h0, detail_r[det_idx[2:0]]};
                end else begin
                    rd_err = 1'b1;
                end
            end
        endcase
    end

    // Answer is prepared in the setup cycle, so every access completes without wait.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            prdata <= (setup & ~pwrite) ? rd_mux : 32'h0;
            pslverr <= setup & rd_err;
        end
    end

    // ----------------------------------------------------------------
    // Assertions.
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_mode_select: assert property (ctrl_r.mode == vsfs_pkg::MODE_UPPER
        |-> base == upper_margin_setpoint_r) else $error("wrong base setpoint");
    a_ceiling_limit: assert property (##1 setpt_r <= $past(setpoint_ceiling_r))
        else $error("setpoint above ceiling");
    a_droop_down: assert property (##1 setpt_r <= $past(no_droop))
        else $error("droop raised the command");
    a_ref_follows: assert property (##1 $stable(setpt_r) && $stable(loop_divider_gain_r)
        |=> $stable(vref)) else $error("reference moved without cause");
    a_alarm_ceiling: assert property (ceiling_alarm |=> detail_r[0][`VSFS_ALARM_BIT])
        else $error("ceiling alarm not latched");
    a_bit_sticky: assert property (detail_r[2][0] && !clr_req |=> detail_r[2][0])
        else $error("status bit dropped");
    a_set_wins: assert property (clr_req && cond_in[16] |=> detail_r[2][0])
        else $error("live condition lost at clear");
    a_clear_all: assert property (clr_req && cond_in == '0 && !ceiling_alarm
        |=> status_word[7:0] == 8'h00)
        else $error("clear left bits set");
    a_latch_off: assert property (state_r == vsfs_pkg::ST_OFF && !clr_req
        |=> state_r == vsfs_pkg::ST_OFF ##1 !out_enable) else $error("latch-off released");
    a_format_nack: assert property (setup && pwrite && paddr == `VSFS_OFF_FORMAT
        && !FORMAT_WRITABLE |=> pslverr && pready) else $error("format write accepted");

    c_ceiling: cover property (ceiling_alarm);
    c_delay_off: cover property (state_r == vsfs_pkg::ST_DELAY ##1 state_r == vsfs_pkg::ST_OFF);
    c_retry_run: cover property (state_r == vsfs_pkg::ST_RETRY ##1 state_r == vsfs_pkg::ST_RUN);
    c_format_err: cover property (pready && pslverr);

endmodule : vout_setpoint_fault_status
`default_nettype wire

//--- host_apb_model.sv
// Host-side APB master model that issues register transfers to the setpoint block.
`timescale 1ns/1ps
`default_nettype none

module host_apb_model (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB master side.
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // ----------------------------------------
    // Transfer engine
    // ----------------------------------------
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    // No cycle count is assumed: the bench timeout is the only way out of a stuck wait.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data lines show a changed pattern so stale values cannot be reused.
        pwdata <= ~wd;
    endtask : xfer
endmodule : host_apb_model

`default_nettype wire

//--- vout_setpoint_fault_status_tb_top.sv
// Self-checking testbench of the setpoint datapath and status logic.
`timescale 1ns/1ps
`default_nettype none
`include "vsfs_params.svh"

module vout_setpoint_fault_status_tb_top;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic signed [15:0] iout_in;
    logic [15:0] sense_in, vref;
    logic [55:0] cond_in;
    logic ctrl_pin, reset_pin, out_enable, ceiling_alarm, er;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [16:0] ex;
    int md[5] = '{0, 1, 2, 1, 2};
    int cur[5] = '{256, 256, -256, 256, 256};
    int cei[5] = '{65535, 65535, 65535, 3840, 65535};
    int usr[5] = '{-16, -16, -16, -16, -32768};

    vout_setpoint_fault_status #(.DELAY_CYC(4), .RETRY_CYC(8)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .iout_in(iout_in), .sense_in(sense_in), .cond_in(cond_in), .ctrl_pin(ctrl_pin),
        .reset_pin(reset_pin), .vref(vref), .out_enable(out_enable),
        .ceiling_alarm(ceiling_alarm));
    host_apb_model host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        host.xfer(1'b1, a, d, rd, er);
        cmp({31'h0, er}, {31'h0, e});
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic e);
        host.xfer(1'b0, a, 32'h0000_0000, rd, er);
        cmp(rd, exp);
        cmp({31'h0, er}, {31'h0, e});
    endtask : rc

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    task automatic pulse(input int b);
        cond_in[b] <= 1'b1;
        tick(1);
        cond_in[b] <= 1'b0;
        tick(4);
    endtask : pulse

    // Reference model: offsets, droop, saturation at zero, ceiling clamp, then loop gain.
    function automatic logic [16:0] model(input int base, input int u, input int f,
                                          input int c, input int ceil, input longint g);
        longint s;
        logic al;
        s = base + u + f;
        if (c > 0) s = s - ((16 * c) >>> 8);
        if (s < 0) s = 0;
        al = (s > ceil);
        if (al) s = ceil;
        return {al, 16'((s * g) >> 16)};
    endfunction : model

    task automatic finish_test;
        if (fail_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 6000) begin
            fail_count++;
            finish_test();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        presetn = 1'b0;
        iout_in = 16'sh0100;
        sense_in = 16'h4000;
        cond_in = 56'h0;
        ctrl_pin = 1'b1;
        reset_pin = 1'b0;
        tick(10);
        presetn <= 1'b1;
        rc(`VSFS_OFF_CTRL, 32'h0000_0004, 1'b0);
        rc(`VSFS_OFF_CEILING, 32'h0000_FFFF, 1'b0);
        rc(`VSFS_OFF_LOOP_GAIN, 32'h0000_8000, 1'b0);
        rc(`VSFS_OFF_FORMAT, 32'h0000_0000, 1'b0);
        wr(`VSFS_OFF_FORMAT, 32'h0000_0005, 1'b1);
        rc(`VSFS_OFF_FORMAT, 32'h0000_0000, 1'b0);
        rc(8'h3C, 32'h0000_0000, 1'b1);
        wr(`VSFS_OFF_NOMINAL, 32'h0000_1000, 1'b0);
        wr(`VSFS_OFF_UPPER, 32'h0000_1200, 1'b0);
        wr(`VSFS_OFF_LOWER, 32'h0000_0E00, 1'b0);
        wr(`VSFS_OFF_FACTORY, 32'h0000_0020, 1'b0);
        wr(`VSFS_OFF_LOADLINE, 32'h0000_0010, 1'b0);
        for (int i = 0; i < 5; i++) begin
            iout_in <= 16'(cur[i]);
            wr(`VSFS_OFF_USER, 32'(16'(usr[i])), 1'b0);
            wr(`VSFS_OFF_CEILING, 32'(cei[i]), 1'b0);
            wr(`VSFS_OFF_CTRL, 32'(4 + md[i]), 1'b0);
            tick(3);
            ex = model(md[i] == 0 ? 4096 : (md[i] == 1 ? 4608 : 3584), usr[i], 32,
                       cur[i], cei[i], 32768);
            cmp({16'h0, vref}, {16'h0, ex[15:0]});
            cmp({31'h0, ceiling_alarm}, {31'h0, ex[16]});
            rc(`VSFS_OFF_REFERENCE, {16'h0, ex[15:0]}, 1'b0);
        end
        wr(`VSFS_OFF_REFERENCE, 32'h0000_1234, 1'b0);
        rc(`VSFS_OFF_REFERENCE, {16'h0, ex[15:0]}, 1'b0);
        rc(`VSFS_OFF_DETAIL0, 32'h0000_0008, 1'b0);
        rc(`VSFS_OFF_READBACK, 32'h0000_2000, 1'b0);
        wr(`VSFS_OFF_MON_GAIN, 32'h0000_C000, 1'b0);
        tick(3);
        rc(`VSFS_OFF_READBACK, 32'h0000_3000, 1'b0);
        wr(`VSFS_OFF_CEILING, 32'h0000_FFFF, 1'b0);
        wr(`VSFS_OFF_CTRL, 32'h0000_0104, 1'b0);
        tick(3);
        pulse(16);
        rc(`VSFS_OFF_DETAIL0 + 8'h08, 32'h0000_0001, 1'b0);
        cmp({31'h0, out_enable}, 32'h1);
        pulse(17);
        pulse(40);
        rc(`VSFS_OFF_DETAIL0 + 8'h08, 32'h0000_0003, 1'b0);
        rc(`VSFS_OFF_STATUS, 32'h0000_0424, 1'b0);
        wr(`VSFS_OFF_CTRL, 32'h0000_0104, 1'b0);
        tick(3);
        rc(`VSFS_OFF_DETAIL0 + 8'h08, 32'h0000_0000, 1'b0);
        rc(`VSFS_OFF_STATUS, 32'h0000_0000, 1'b0);
        cond_in[16] <= 1'b1;
        wr(`VSFS_OFF_CTRL, 32'h0000_0104, 1'b0);
        tick(3);
        rc(`VSFS_OFF_DETAIL0 + 8'h08, 32'h0000_0001, 1'b0);
        cond_in[16] <= 1'b0;
        reset_pin <= 1'b1;
        tick(1);
        reset_pin <= 1'b0;
        tick(3);
        rc(`VSFS_OFF_DETAIL0 + 8'h08, 32'h0000_0000, 1'b0);
        wr(`VSFS_OFF_CTRL, 32'h0000_000C, 1'b0);
        pulse(4);
        tick(20);
        cmp({31'h0, out_enable}, 32'h0);
        rc(`VSFS_OFF_STATUS, 32'h0000_0181, 1'b0);
        wr(`VSFS_OFF_CTRL, 32'h0000_0008, 1'b0);
        wr(`VSFS_OFF_CTRL, 32'h0000_000C, 1'b0);
        tick(4);
        cmp({31'h0, out_enable}, 32'h1);
        rc(`VSFS_OFF_DETAIL0, 32'h0000_0000, 1'b0);
        wr(`VSFS_OFF_CTRL, 32'h0000_0014, 1'b0);
        pulse(5);
        cmp({31'h0, out_enable}, 32'h0);
        tick(12);
        cmp({31'h0, out_enable}, 32'h1);
        wr(`VSFS_OFF_CTRL, 32'h0000_001C, 1'b0);
        cond_in[6] <= 1'b1;
        tick(2);
        cmp({31'h0, out_enable}, 32'h1);
        tick(10);
        cmp({31'h0, out_enable}, 32'h0);
        cond_in[6] <= 1'b0;
        wr(`VSFS_OFF_CTRL, 32'h0000_0104, 1'b0);
        pulse(7);
        cmp({31'h0, out_enable}, 32'h1);
        ctrl_pin <= 1'b0;
        tick(3);
        cmp({31'h0, out_enable}, 32'h0);
        ctrl_pin <= 1'b1;
        tick(3);
        rc(`VSFS_OFF_DETAIL0, 32'h0000_0000, 1'b0);
        cmp({31'h0, out_enable}, 32'h1);
        finish_test();
    end
endmodule : vout_setpoint_fault_status_tb_top

`default_nettype wire
